// File: cfs_pkg.sv
package cfs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned T_TXDOM_US = 700;
    localparam int unsigned T_PERMDOM_US = 700;
    localparam int unsigned T_FOLLOW_NS = 275;
    localparam int unsigned TXDOM_CYC = T_TXDOM_US * CLK_MHZ;
    localparam int unsigned PERMDOM_CYC = T_PERMDOM_US * CLK_MHZ;
    // least wait for the echo, rounded up
    localparam int unsigned FOLLOW_CYC = (T_FOLLOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MISS_LIMIT = 4;

    localparam int unsigned TMR_W = 17;
    localparam int unsigned FOL_W = 5;
    localparam int unsigned MISS_W = 3;
    localparam logic [FOL_W-1:0] FOL_LAST = FOL_W'(FOLLOW_CYC - 1);
    localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(MISS_LIMIT - 1);

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_STATE = 12'h00c;

    localparam int unsigned ST_W = 5;
    localparam int unsigned B_TXDOM = 0;
    localparam int unsigned B_BUSREC = 1;
    localparam int unsigned B_PERMDOM = 2;
    localparam int unsigned B_ECHO = 3;
    localparam int unsigned B_ERR = 4;
    localparam logic [ST_W-1:0] OFF_MASK = 5'h0b;
    localparam int unsigned B_DIS = 0;

    typedef struct packed {
        logic armed;
        logic [FOL_W-1:0] wait_cnt;
        logic [MISS_W-1:0] miss;
        logic hit;
    } cfs_fol_t;

    typedef struct packed {
        logic [1:0] s_tx;
        logic [1:0] s_bus;
        logic [1:0] s_echo;
        logic tx_prev;
        logic dis;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [TMR_W-1:0] tx_tmr;
        logic [TMR_W-1:0] bus_tmr;
        logic can_tx_drv;
        logic can_rx_out;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cfs_top_t;
endpackage

// File: cfs_follow_chk.sv
`timescale 1ns/1ps
module cfs_follow_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic en,
    input wire logic clear,
    input wire logic tx_dom,
    input wire logic tx_fall,
    input wire logic seen_dom,
    output logic hit
);
    cfs_pkg::cfs_fol_t q;
    cfs_pkg::cfs_fol_t n;

    always_comb begin
        n = q;
        n.hit = 1'b0;
        if (!en) begin
            n = '0;
        end else if (tx_fall) begin
            n.armed = 1'b1;
            n.wait_cnt = '0;
        end else if (q.armed) begin
            if (!tx_dom) begin
                // frame bit too short to judge
                n.armed = 1'b0;
            end else if (seen_dom) begin
                n.armed = 1'b0;
                n.miss = '0;
            end else if (q.wait_cnt == cfs_pkg::FOL_LAST) begin
                n.armed = 1'b0;
                if (q.miss == cfs_pkg::MISS_LAST) begin
                    n.hit = 1'b1;
                    n.miss = '0;
                end else begin
                    n.miss = miss_inc(q.miss);
                end
            end else begin
                n.wait_cnt = q.wait_cnt + 5'h01;
            end
        end
        // a hit found in the clearing cycle still goes out, the fault outranks the clear
        if (en && clear) begin
            n.armed = 1'b0;
            n.wait_cnt = '0;
            n.miss = '0;
        end
    end

    function automatic logic [cfs_pkg::MISS_W-1:0] miss_inc(input logic [cfs_pkg::MISS_W-1:0] v);
        miss_inc = v + 3'h1;
    endfunction

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign hit = q.hit;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    miss_count_a: assert property (hit |-> $past(q.miss) == cfs_pkg::MISS_LAST)
        else $error("follow fault flagged before the fourth miss");
    miss_wait_a: assert property (hit |-> $past(q.wait_cnt) == cfs_pkg::FOL_LAST && $past(tx_dom))
        else $error("follow fault flagged before the echo wait ended");
endmodule

// File: cfs_top.sv
// Overview of operation
// - flag permanent dominant when the bus stays low longer than 700 us.
// - permanent dominant status latches; software reads it and clears it by writing one.
// - permanent dominant only reports; the transmitter stays enabled.
// - four echo misses after transmit goes dominant disable the transmitter.
// - echo status latches; transmitter stays off until software clears it.
// - transmit dominant too long or bus not following four times disables transmitter.
// - any fault sets the common error bit; one control bit disables all handling.
// - low on transmit or receive means dominant, high means recessive.
// - disabling for a missed bus follow takes effect on the fourth miss.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cfs_top #(
    parameter logic [16:0] TXDOM_LIM = 17'(cfs_pkg::TXDOM_CYC),
    parameter logic [16:0] PERMDOM_LIM = 17'(cfs_pkg::PERMDOM_CYC)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic can_tx,
    input wire logic bus_rx,
    input wire logic rx_echo,
    output logic can_tx_drv,
    output logic can_rx_out,
    output logic irq
);
    cfs_pkg::cfs_top_t q;
    cfs_pkg::cfs_top_t n;
    logic tx;
    logic bus;
    logic echo;
    logic tx_fall;
    logic en;
    logic acc;
    logic done;
    logic wr;
    logic tx_off;
    logic busrec_hit;
    logic echo_hit;
    logic [cfs_pkg::ST_W-1:0] clr;
    logic [cfs_pkg::ST_W-1:0] set;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == cfs_pkg::ADDR_CTRL) || (a == cfs_pkg::ADDR_STATUS) ||
                 (a == cfs_pkg::ADDR_MASK) || (a == cfs_pkg::ADDR_STATE);
    endfunction

    // synchronised views, low is dominant
    assign tx = q.s_tx[1];
    assign bus = q.s_bus[1];
    assign echo = q.s_echo[1];
    assign tx_fall = q.tx_prev & ~tx;
    assign en = ~q.dis;
    assign acc = psel & penable;
    assign done = acc & q.pready;
    assign wr = done & pwrite;
    assign clr = (wr && paddr == cfs_pkg::ADDR_STATUS) ? pwdata[cfs_pkg::ST_W-1:0] : '0;

    cfs_follow_chk u_bus_chk (
        .mclk(mclk),
        .rst(rst),
        .en(en),
        .clear(clr[cfs_pkg::B_BUSREC]),
        .tx_dom(~tx),
        .tx_fall(tx_fall),
        .seen_dom(~bus),
        .hit(busrec_hit)
    );

    cfs_follow_chk u_echo_chk (
        .mclk(mclk),
        .rst(rst),
        .en(en),
        .clear(clr[cfs_pkg::B_ECHO]),
        .tx_dom(~tx),
        .tx_fall(tx_fall),
        .seen_dom(~echo),
        .hit(echo_hit)
    );

    always_comb begin
        n = q;
        set = '0;
        n.s_tx = {q.s_tx[0], can_tx};
        n.s_bus = {q.s_bus[0], bus_rx};
        n.s_echo = {q.s_echo[0], rx_echo};
        n.tx_prev = tx;

        if (!en || tx || clr[cfs_pkg::B_TXDOM]) begin
            n.tx_tmr = '0;
        end else if (q.tx_tmr != TXDOM_LIM) begin
            n.tx_tmr = q.tx_tmr + 17'h00001;
        end
        if (!en || bus || clr[cfs_pkg::B_PERMDOM]) begin
            n.bus_tmr = '0;
        end else if (q.bus_tmr != PERMDOM_LIM) begin
            n.bus_tmr = q.bus_tmr + 17'h00001;
        end

        set[cfs_pkg::B_TXDOM] = en & ~tx & (q.tx_tmr == TXDOM_LIM);
        set[cfs_pkg::B_PERMDOM] = en & ~bus & (q.bus_tmr == PERMDOM_LIM);
        set[cfs_pkg::B_BUSREC] = en & busrec_hit;
        set[cfs_pkg::B_ECHO] = en & echo_hit;
        set[cfs_pkg::B_ERR] = |set[cfs_pkg::B_ECHO:cfs_pkg::B_TXDOM];
        // a new event outranks the same-cycle clear
        n.status = (q.status & ~clr) | set;

        if (wr && paddr == cfs_pkg::ADDR_CTRL) begin
            n.dis = pwdata[cfs_pkg::B_DIS];
        end
        if (wr && paddr == cfs_pkg::ADDR_MASK) begin
            n.mask = pwdata[cfs_pkg::ST_W-1:0];
        end

        // permanent dominant is absent from the off mask
        tx_off = ~n.dis & (|(n.status & cfs_pkg::OFF_MASK));

        // one wait state so every bus output comes from a flop
        n.pready = acc & ~q.pready;
        n.pslverr = acc & ~q.pready & ~mapped(paddr);
        n.prdata = '0;
        if (acc && !q.pready && !pwrite) begin
            unique case (paddr)
                cfs_pkg::ADDR_CTRL: n.prdata = {31'h0, q.dis};
                cfs_pkg::ADDR_STATUS: n.prdata = {27'h0, q.status};
                cfs_pkg::ADDR_MASK: n.prdata = {27'h0, q.mask};
                cfs_pkg::ADDR_STATE: n.prdata = {28'h0, echo, bus, tx, ~tx_off};
                default: n.prdata = '0;
            endcase
        end

        n.can_tx_drv = tx_off | tx;
        n.can_rx_out = bus;
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
            q.s_tx <= 2'h3;
            q.s_bus <= 2'h3;
            q.s_echo <= 2'h3;
            q.tx_prev <= 1'b1;
            q.can_tx_drv <= 1'b1;
            q.can_rx_out <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign can_tx_drv = q.can_tx_drv;
    assign can_rx_out = q.can_rx_out;
    assign irq = q.irq;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    permdom_time_a: assert property ($rose(q.status[cfs_pkg::B_PERMDOM]) |->
            $past(q.bus_tmr) == PERMDOM_LIM && !$past(bus))
        else $error("permanent dominant flagged at the wrong time");
    permdom_clear_a: assert property (clr[cfs_pkg::B_PERMDOM] && !set[cfs_pkg::B_PERMDOM] |=>
            !q.status[cfs_pkg::B_PERMDOM] && q.bus_tmr == '0)
        else $error("permanent dominant status not cleared");
    permdom_keep_a: assert property (q.status[cfs_pkg::B_PERMDOM] ##1
            (q.status & cfs_pkg::OFF_MASK) == '0 |-> can_tx_drv == $past(tx))
        else $error("transmitter gated by permanent dominant");
    tx_gated_a: assert property (!q.dis && (q.status & cfs_pkg::OFF_MASK) != '0 |-> can_tx_drv)
        else $error("transmitter driven while a disabling fault is latched");
    txdom_set_a: assert property (q.tx_tmr == TXDOM_LIM && !tx && !q.dis |=>
            q.status[cfs_pkg::B_TXDOM] ##1 can_tx_drv)
        else $error("transmit dominant timeout missed");
    err_common_a: assert property ((q.status[3:0] & ~$past(q.status[3:0])) != '0 |->
            q.status[cfs_pkg::B_ERR])
        else $error("common error bit not set with a fault");
    dis_quiet_a: assert property ($past(q.dis) |-> (q.status & ~$past(q.status)) == '0)
        else $error("fault latched while handling disabled");
    rx_pass_a: assert property (can_rx_out == $past(bus))
        else $error("receive output does not follow the bus");
    timer_restart_a: assert property (clr[cfs_pkg::B_TXDOM] |=> q.tx_tmr == '0)
        else $error("dominant timer not restarted by clear");
endmodule

// File: cfs_mcu_model.sv
`timescale 1ns/1ps
module cfs_mcu_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [7:0] len,
    output logic can_tx
);
    logic [7:0] left = 8'h00;
    // low while a dominant stretch is being sent
    assign can_tx = (left == 8'h00);
    always @(posedge mclk) begin
        if (go) begin
            left <= len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, mid_drv, mid_rx, can_tx, bus_rx, rx_echo, can_tx_drv, can_rx_out, irq;
    logic go = 1'b0;
    logic bus_rec = 1'b0;
    logic bus_dom = 1'b0;
    logic echo_rec = 1'b0;
    logic [7:0] len = 8'h00;
    int n_errors = 0;
    int checks = 0;
    always #5 mclk = ~mclk;
    // bus and echo follow the driver unless a fault is injected
    assign bus_rx = ~bus_dom & (bus_rec | can_tx_drv);
    assign rx_echo = echo_rec | can_tx_drv;
    cfs_top #(.TXDOM_LIM(17'd50), .PERMDOM_LIM(17'd200)) u_dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .can_tx(can_tx), .bus_rx(bus_rx), .rx_echo(rx_echo),
        .can_tx_drv(can_tx_drv), .can_rx_out(can_rx_out), .irq(irq));
    cfs_mcu_model u_mcu (.mclk(mclk), .go(go), .len(len), .can_tx(can_tx));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // drive n dominant stretches, sampling the driver near each one's end
    task pulses(input int n, input logic [7:0] l);
        repeat (n) begin
            @(posedge mclk);
            go <= 1'b1;
            len <= l;
            @(posedge mclk);
            go <= 1'b0;
            repeat (int'(l) - 5) @(posedge mclk);
            mid_drv = can_tx_drv;
            mid_rx = can_rx_out;
            repeat (45) @(posedge mclk);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
        wr(cfs_pkg::ADDR_MASK, 32'h1f);
        rd(cfs_pkg::ADDR_MASK, 32'h1f);
        $display("register test done");
        echo_rec <= 1'b1;
        pulses(3, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        pulses(1, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h18);
        chk(32'(irq), 32'h1);
        pulses(1, 8'd40);
        chk(32'(mid_drv), 32'h1);
        chk(32'(mid_rx), 32'h1);
        wr(cfs_pkg::ADDR_STATUS, 32'h18);
        pulses(3, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        echo_rec <= 1'b0;
        pulses(1, 8'd40);
        chk(32'(mid_drv), 32'h0);
        chk(32'(mid_rx), 32'h0);
        chk(32'(irq), 32'h0);
        $display("echo test done");
        bus_rec <= 1'b1;
        pulses(3, 8'd40);
        bus_rec <= 1'b0;
        pulses(1, 8'd40);
        bus_rec <= 1'b1;
        pulses(3, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        pulses(1, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h12);
        pulses(1, 8'd40);
        chk(32'(mid_drv), 32'h1);
        bus_rec <= 1'b0;
        wr(cfs_pkg::ADDR_STATUS, 32'h1f);
        pulses(1, 8'd90);
        rd(cfs_pkg::ADDR_STATUS, 32'h11);
        chk(32'(mid_drv), 32'h1);
        wr(cfs_pkg::ADDR_STATUS, 32'h1f);
        $display("transmit fault test done");
        wr(cfs_pkg::ADDR_MASK, 32'h0);
        bus_dom <= 1'b1;
        pulses(6, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h14);
        chk(32'(mid_drv), 32'h0);
        chk(32'(irq), 32'h0);
        wr(cfs_pkg::ADDR_MASK, 32'h04);
        bus_dom <= 1'b0;
        rd(cfs_pkg::ADDR_STATE, 32'h0f);
        chk(32'(irq), 32'h1);
        wr(cfs_pkg::ADDR_STATUS, 32'h14);
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        $display("permanent dominant test done");
        wr(cfs_pkg::ADDR_CTRL, 32'h1);
        rd(cfs_pkg::ADDR_CTRL, 32'h1);
        echo_rec <= 1'b1;
        pulses(4, 8'd40);
        rd(cfs_pkg::ADDR_STATUS, 32'h0);
        chk(32'(mid_drv), 32'h0);
        echo_rec <= 1'b0;
        wr(cfs_pkg::ADDR_CTRL, 32'h0);
        $display("disable test done");
        print_verdict();
    end
endmodule
